//--- bench/lsie_checker_asserts.sv
// Purpose: Port checks for the line status event block
// Assumes: Bound to the top module; masks are internal
// Notes:   Event timing per condition is judged in the bench
`default_nettype none

module lsie_checker #(
    parameter int LOSS_CYCLES = 70
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData_r,
    // Levels and request
    input wire logic       signalLossDet,
    input wire logic       remoteLoopActive,
    input wire logic       intReq_r
);
    timeunit 1ns;
    timeprecision 1ns;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    rst_clear_a: assert property ($rose(rst_b) |->
        !intReq_r && regRdData_r == 8'h00) else $error("dirty reset");
    req_holds_a: assert property (intReq_r &&
        !(regRdEn && regAddr == 8'h19) |=> intReq_r) else $error("req drop");
    data_holds_a: assert property (!regRdEn |=>
        $stable(regRdData_r)) else $error("read data moved");
    loop_live_a: assert property (regRdEn && regAddr == 8'h18 &&
        $stable(remoteLoopActive) |=> regRdData_r ==
        {2'h0, $past(remoteLoopActive), 5'h00}) else $error("loop bit");
    flag_live_a: assert property (regRdEn && regAddr == 8'h17 &&
        $stable(signalLossDet) |=> regRdData_r[0] == $past(signalLossDet))
        else $error("loss flag");
    upper_zero_a: assert property (regRdEn &&
        regAddr inside {8'h16, 8'h17, 8'h19} |=> regRdData_r[7:5] == 3'h0)
        else $error("upper bits set");
    mask_top_a: assert property (regRdEn && regAddr == 8'h14 |=>
        regRdData_r[7:5] == 3'h7) else $error("mask upper bits");
    unmapped_zero_a: assert property (regRdEn && regAddr == 8'h10
        |=> regRdData_r == 8'h00) else $error("unmapped read");

    // Main scenarios reached
    cover property ($rose(intReq_r));
    cover property (regRdEn && regAddr == 8'h19 && intReq_r);
    cover property (regRdEn && regAddr == 8'h18 && remoteLoopActive);
endmodule : lsie_checker

bind line_status_interrupt_events lsie_checker #(
    .LOSS_CYCLES(LOSS_CYCLES)
) uChk (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .signalLossDet(signalLossDet), .remoteLoopActive(remoteLoopActive),
    .intReq_r(intReq_r)
);

`default_nettype wire

//--- bench/test_line_status_interrupt_events.sv
// Purpose: Self-checking bench for the line status event block
// Assumes: Clock-loss count cut to 5 so the run stays short
// Notes:   Inputs change on the falling edge only
`default_nettype none

module test_line_status_interrupt_events;
    timeunit 1ns;
    timeprecision 1ns;

    logic       sys_clk;
    logic       rst_b;
    logic [7:0] regAddr;
    logic       regWrEn;
    logic [7:0] regWrData;
    logic       regRdEn;
    logic [7:0] regRdData_r;
    logic [4:0] cond;
    logic [7:0] bitV;
    logic       loopOn;
    logic       txClk;
    logic       intReq_r;
    int         failures;
    int         nTests;

    // Bit 3 of cond stops the line clock instead of driving a level
    line_status_interrupt_events #(
        .LOSS_CYCLES(5)
    ) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData_r(regRdData_r), .patternSyncDet(cond[4]),
        .driverShortDet(cond[2]), .alarmIndDet(cond[1]),
        .signalLossDet(cond[0]), .remoteLoopActive(loopOn),
        .transmit_line_clock(txClk), .intReq_r(intReq_r)
    );

    // 10 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Line clock runs unless the clock-loss case holds it; one driver only
    initial
    begin
        txClk = 1'b0;
        forever
        begin
            @(negedge sys_clk);
            if (!cond[3])
                txClk <= ~txClk;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask : wr

    // Read data is registered, so it is settled by the next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        chk(regRdData_r, exp);
    endtask : rd

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        cond = 5'h00;
        loopOn = 1'b0;
        failures = 0;
        nTests = 0;
        idle(5);
        rst_b = 1'b1;
        rd(8'h14, 8'hff);
        rd(8'h16, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h19, 8'h00);
        wr(8'h14, 8'h00);
        // Raise then drop each condition, rising-only then both edges
        for (int s = 0; s < 2; s++)
        begin
            wr(8'h16, s ? 8'h1f : 8'h00);
            rd(8'h16, s ? 8'h1f : 8'h00);
            for (int i = 0; i < 5; i++)
            begin
                bitV = 8'h01 << i;
                cond[i] <= 1'b1;
                idle(16);
                rd(8'h17, bitV);
                chk({7'h00, intReq_r}, 8'h01);
                rd(8'h19, bitV);
                chk({7'h00, intReq_r}, 8'h00);
                rd(8'h19, 8'h00);
                cond[i] <= 1'b0;
                idle(16);
                rd(8'h19, s ? bitV : 8'h00);
            end
        end
        // Clock loss: the flag sets only after more than 5 idle clocks
        cond[3] <= 1'b1;
        idle(9);
        rd(8'h17, 8'h00);
        chk({7'h00, intReq_r}, 8'h00);
        idle(1);
        chk({7'h00, intReq_r}, 8'h01);
        rd(8'h19, 8'h08);
        cond[3] <= 1'b0;
        idle(16);
        rd(8'h19, 8'h08);
        // Per-bit selects: only bit 0 takes falling changes
        wr(8'h16, 8'h01);
        cond[1:0] <= 2'h3;
        idle(16);
        rd(8'h19, 8'h03);
        cond[1:0] <= 2'h0;
        idle(16);
        rd(8'h19, 8'h01);
        // An event landing in the read-clear cycle survives the clear
        cond[1] <= 1'b1;
        rd(8'h19, 8'h00);
        rd(8'h19, 8'h02);
        cond[1] <= 1'b0;
        // A masked condition raises nothing
        wr(8'h14, 8'h01);
        rd(8'h14, 8'he1);
        cond[0] = 1'b1;
        idle(16);
        rd(8'h19, 8'h00);
        chk({7'h00, intReq_r}, 8'h00);
        cond[0] = 1'b0;
        // Loopback is live and status registers ignore writes
        loopOn = 1'b1;
        wr(8'h18, 8'h00);
        rd(8'h18, 8'h20);
        loopOn = 1'b0;
        wr(8'h17, 8'hff);
        rd(8'h18, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h10, 8'h00);
        report_and_stop();
    end
endmodule : test_line_status_interrupt_events

`default_nettype wire

//--- core/line_status_interrupt_events.sv
// Purpose: Line status flags, edge-selected interrupt events, mask
// Assumes: Detector levels come from logic on sys_clk
// Notes:   Read data is registered, one cycle after the read strobe.
//          A read of the interrupt status clears it, but an event that
//          lands in the same cycle stays set, so no change is lost.
//          Detector levels get no synchroniser here; only the line
//          clock pin is synchronised, inside the loss detector.
//
// What this block does
// - Pattern-sync select: rising only, or both
// - Clock-loss select: rising only, or both
// - Driver-fail select: rising only, or both
// - Alarm-indication select: rising only, or both
// - Signal-loss select: rising only, or both
// - Bit 4 shows live pattern sync
// - Clock loss after over 70 idle clocks
// - Bit 2 shows driver short circuit
// - Bit 1 shows alarm indication detected
// - Bit 0 shows loss of signal
// - Event counts only when its mask is 0
// - Second status bit 5 shows remote loopback
// - Second status read-only, live, unlatched
// - Mask 1 blocks, 0 allows; resets to 1
// - Events latch status; read clears it
`include "lsie_map.svh"
`default_nettype none

module line_status_interrupt_events #(
    parameter int LOSS_CYCLES = `LSIE_TX_CLOCK_LOSS_CYCLES
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Register port
    input  wire logic [7:0]        regAddr,
    input  wire logic              regWrEn,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regRdEn,
    output var  logic [7:0]        regRdData_r,
    // Detector levels and pin
    input  wire logic              patternSyncDet,
    input  wire logic              driverShortDet,
    input  wire logic              alarmIndDet,
    input  wire logic              signalLossDet,
    input  wire logic              remoteLoopActive,
    input  wire logic              transmit_line_clock,
    // Interrupt request
    output var  logic              intReq_r
);

    // One event slice per monitored condition
    localparam int NCOND = $bits(lsie_pkg::cond_vec_t);

    // Sampled flags and their previous copy for the edge compare
    lsie_pkg::cond_vec_t flags_r;
    lsie_pkg::cond_vec_t flagsPrev_r;
    // Software-written selects and masks
    lsie_pkg::cond_vec_t edgeSel_r;
    lsie_pkg::cond_vec_t mask_r;
    // Latched event status
    lsie_pkg::cond_vec_t intStatus_r;
    lsie_pkg::cond_vec_t intStatus_nxt;
    // Per-condition events, one continuous driver per bit
    wire lsie_pkg::cond_vec_t events;
    lsie_pkg::cond_vec_t liveFlags;
    logic                remoteLoop_r;
    logic                clockMissing;
    logic                statusClear;

    // Address match, used by writes and the read-clear; reads decode by case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // Condition word placed as one byte with reserved bits
    function automatic lsie_pkg::reg_byte_t pack(
        input lsie_pkg::cond_vec_t v,
        input logic [2:0]          hi
    );
        pack = {hi, v};
    endfunction : pack

    // Line clock loss detector; its flag leaves it already registered
    tx_clock_loss_detect #(
        .LOSS_CYCLES         (LOSS_CYCLES)
    ) uClockLoss (
        .sys_clk             (sys_clk),
        .rst_b               (rst_b),
        .transmit_line_clock (transmit_line_clock),
        .clockMissing_r      (clockMissing)
    );

    // Detector levels gathered at their status bit positions
    // The clock-loss bit comes from the detector, not from a level input
    always_comb
    begin
        liveFlags = '0;
        liveFlags[`LSIE_BIT_PATTERN_SYNC]  = patternSyncDet;
        liveFlags[`LSIE_BIT_TX_CLOCK_LOSS] = clockMissing;
        liveFlags[`LSIE_BIT_DRIVER_FAIL]   = driverShortDet;
        liveFlags[`LSIE_BIT_ALARM_IND]     = alarmIndDet;
        liveFlags[`LSIE_BIT_SIGNAL_LOSS]   = signalLossDet;
    end

    // Flags sampled every clock; the previous copy feeds edge compare
    // Both copies reset to zero, so no false edge follows reset
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags_r     <= `LSIE_RST_FLAGS;
            flagsPrev_r <= `LSIE_RST_FLAGS;
        end
        else
        begin
            flags_r     <= liveFlags;
            flagsPrev_r <= flags_r;
        end
    end

    // Remote loopback is shown live, never latched
    // One register stage keeps it in step with the other status bits
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            remoteLoop_r <= 1'b0;
        else
            remoteLoop_r <= remoteLoopActive;
    end

    // Software writes to the edge select register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            edgeSel_r <= `LSIE_RST_EDGE_SELECT;
        else if (regWrEn && hit(regAddr, `LSIE_OFS_EDGE_SELECT))
            edgeSel_r <= regWrData[4:0];
    end

    // Software writes to the mask; reserved bits 7-5 are not stored
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_r <= `LSIE_RST_MASK;
        else if (regWrEn && hit(regAddr, `LSIE_OFS_MASK_PRIMARY))
            mask_r <= regWrData[4:0];
    end

    // Per-condition event: rising always, falling when selected
    generate
        for (genvar i = 0; i < NCOND; i++)
        begin : gEvent
            logic rise;
            logic fall;
            // Rising change always qualifies
            assign rise = flags_r[i] & ~flagsPrev_r[i];
            // Falling change only when its select bit asks for both
            assign fall = ~flags_r[i] & flagsPrev_r[i] &
                          edgeSel_r[i];
            // Bits 4..0 cover the five selects in the same loop
            assign events[i] = ~mask_r[i] & (rise | fall);
        end
    endgenerate

    // Read of the status register clears it; a new event still wins
    assign statusClear = regRdEn & hit(regAddr, `LSIE_OFS_INT_STATUS);

    // Clear first, then merge new events, so a set beats a clear
    always_comb
    begin
        intStatus_nxt = intStatus_r;
        if (statusClear)
            intStatus_nxt = '0;
        intStatus_nxt = intStatus_nxt | events;
    end

    // Latched event status, held until software reads it
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            intStatus_r <= `LSIE_RST_INT_STATUS;
        else
            intStatus_r <= intStatus_nxt;
    end

    // Request follows the latched status, so it drops with the clear
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            intReq_r <= 1'b0;
        else
            intReq_r <= |intStatus_nxt;
    end

    // Registered read mux; unmapped addresses read zero
    // Reserved bits read zero except the mask's, which read one
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdData_r <= `LSIE_RST_READ_DATA;
        else if (regRdEn)
        begin
            case (regAddr)
                `LSIE_OFS_MASK_PRIMARY:
                    regRdData_r <= pack(mask_r, `LSIE_MASK_RSVD_READ);
                `LSIE_OFS_EDGE_SELECT:
                    regRdData_r <= pack(edgeSel_r, 3'h0);
                `LSIE_OFS_STATUS_PRIMARY:
                    regRdData_r <= pack(flags_r, 3'h0);
                `LSIE_OFS_STATUS_SECOND:
                    regRdData_r <= {2'h0, remoteLoop_r, 5'h00};
                `LSIE_OFS_INT_STATUS:
                    regRdData_r <= pack(intStatus_r, 3'h0);
                default:
                    regRdData_r <= 8'h00;
            endcase
        end
    end

endmodule : line_status_interrupt_events

`default_nettype wire

//--- core/lsie_map.svh
// Purpose: Register offsets, bit positions, resets and timing counts
// Assumes: Included by its bare name from the line status block files
// Notes:   Definitions only
`ifndef LSIE_MAP_SVH
`define LSIE_MAP_SVH

// Register offsets on the byte-wide register port
`define LSIE_OFS_MASK_PRIMARY    8'h14
`define LSIE_OFS_EDGE_SELECT     8'h16
`define LSIE_OFS_STATUS_PRIMARY  8'h17
`define LSIE_OFS_STATUS_SECOND   8'h18
`define LSIE_OFS_INT_STATUS      8'h19

// Condition bit positions 4-0, shared by flags, masks, selects, int status; bit 5 is remote loopback in second status
`define LSIE_BIT_PATTERN_SYNC    4
`define LSIE_BIT_TX_CLOCK_LOSS   3
`define LSIE_BIT_DRIVER_FAIL     2
`define LSIE_BIT_ALARM_IND       1
`define LSIE_BIT_SIGNAL_LOSS     0
`define LSIE_BIT_REMOTE_LOOP     5

// Reset values
`define LSIE_RST_MASK            5'h1f
`define LSIE_RST_EDGE_SELECT     5'h00
`define LSIE_RST_FLAGS           5'h00
`define LSIE_RST_INT_STATUS      5'h00
`define LSIE_RST_READ_DATA       8'h00

// Reserved mask bits 7-5 read back as ones
`define LSIE_MASK_RSVD_READ      3'h7

// Transmit clock counts as lost after more than this many clocks
`define LSIE_TX_CLOCK_LOSS_CYCLES 70

`endif

//--- core/lsie_pkg.sv
// Purpose: Types shared by the line status interrupt event block
// Assumes: Constants live in lsie_map.svh
// Notes:   Types only
`default_nettype none

package lsie_pkg;

    // One byte of register data
    typedef logic [7:0] reg_byte_t;

    // One bit per monitored condition, bit 4 down to bit 0
    typedef logic [4:0] cond_vec_t;

endpackage : lsie_pkg

`default_nettype wire

//--- core/tx_clock_loss_detect.sv
// Purpose: Flags a transmit line clock that has stopped toggling
// Assumes: Clock pin is asynchronous to sys_clk
// Notes:   Pin passes two flip-flops before the toggle compare
`include "lsie_map.svh"
`default_nettype none

module tx_clock_loss_detect #(
    parameter int LOSS_CYCLES = `LSIE_TX_CLOCK_LOSS_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // Pin and result
    input  wire logic transmit_line_clock,
    output var  logic clockMissing_r
);

    localparam int CW = $clog2(LOSS_CYCLES + 2);
    localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

    logic          syncA_r;
    logic          syncB_r;
    logic          lastLevel_r;
    logic [CW-1:0] idleCount_r;

    // Two-stage synchroniser; stage A is read only by stage B
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syncA_r     <= 1'b0;
            syncB_r     <= 1'b0;
            lastLevel_r <= 1'b0;
        end
        else
        begin
            syncA_r     <= transmit_line_clock;
            syncB_r     <= syncA_r;
            lastLevel_r <= syncB_r;
        end
    end

    // Idle counter restarts on any toggle, saturates above the limit
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            idleCount_r <= '0;
        else if (syncB_r != lastLevel_r)
            idleCount_r <= '0;
        else if (idleCount_r <= LIMIT)
            idleCount_r <= idleCount_r + CW'(1);
    end

    // Loss means strictly more than the limit without a toggle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            clockMissing_r <= 1'b0;
        else
            clockMissing_r <= (idleCount_r > LIMIT);
    end

endmodule : tx_clock_loss_detect

`default_nettype wire
